// file: common/tof_cfg_consts.vh
// Functional notes
// - interrupt raised when any enabled source fires and its irq mask bit is set: timeout bit31, end-hits bit30, alu bit29.
// - end of nonvolatile memory action is a further source, enabled by word 6 bit 21.
// - per stop channel, edge bit clear gives one edge, set gives both edges.
// - three stop gate delay values held, hits one to three of channel 1.
// - each delay is unsigned 14.5 fixed point in reference clock periods.
// - with error option on, a timeout makes the result read 0fffffff.
// - timeout predivider codes 0..3 give 64, 256, 1024, 4096 us at 4 MHz.
// - output config: bit31 both outputs, downstream inverted; bit30 up; bit29 down.
// - start noise bit set switches on the start channel noise unit.
// - phase noise unit active when its disable bit is zero.
// - three-bit field sets fire sequence repetitions, zero to seven.
// - per pulse phase field, one bit per pulse, up to 15 pulses.
// - phase bit zero no inversion, one inverts that pulse.
// - low eight bits of each word are free storage without effect.
// - analog enable powers analog only during measurement, stops become analog inputs.
`ifndef TOF_CFG_CONSTS_VH
`define TOF_CFG_CONSTS_VH
`define CFG_IDX_W2 4'h2
`define CFG_IDX_W3 4'h3
`define CFG_IDX_W4 4'h4
`define CFG_IDX_W5 4'h5
`define CFG_IDX_W6 4'h6
`define CFG_IDX_IRQ_STAT 4'h8
`define CFG_IDX_IRQ_MASK 4'h9
`define CFG_RST_W2 32'h20000000
`define CFG_RST_W3 32'h18000000
`define CFG_RST_W4 32'h20000000
`define CFG_RST_W5 32'h00000000
`define CFG_RST_W6 32'h00000000
`define F_IRQ_EN_HI 31
`define F_IRQ_EN_LO 29
`define F_EDGE2 28
`define F_EDGE1 27
`define F_DELAY_HI 26
`define F_DELAY_LO 8
`define F_ERRVAL 29
`define F_TIMO_HI 28
`define F_TIMO_LO 27
`define F_CONF_HI 31
`define F_CONF_LO 29
`define F_SNOISE 28
`define F_PNOISE_OFF 27
`define F_REP_HI 26
`define F_REP_LO 24
`define F_PH_HI 23
`define F_PH_LO 8
`define F_TAG_HI 7
`define F_W6_NVM_EN 21
`define F_W6_ANALOG 11
`define TIMEOUT_ERR_CODE 32'h0fffffff
`define HS_CLK_MHZ 4
`define TIMO_US_0 64
`define TIMO_US_1 256
`define TIMO_US_2 1024
`define TIMO_US_3 4096
`define TIMO_CYC_0 18'h00100
`define TIMO_CYC_1 18'h00400
`define TIMO_CYC_2 18'h01000
`define TIMO_CYC_3 18'h04000
`endif

// file: design/tof_edge_detect.v
`timescale 1ns/100ps
// stop input synchroniser with single or dual edge detection
module tof_edge_detect
(
   input wire core_clk_i,
   input wire reset_i,
   input wire stop_pin_i,
   input wire both_edges_i,
   input wire falling_sel_i,
   output reg hit_o
);
   reg sync1_q;
   reg sync2_q;
   reg prev_q;
   wire rise;
   wire fall;

   assign rise = sync2_q & ~prev_q;
   assign fall = ~sync2_q & prev_q;

   always @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q <= 1'b0;
         hit_o <= 1'b0;
      end
      else
      begin
         sync1_q <= stop_pin_i;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
         if (both_edges_i)
            hit_o <= rise | fall;
         else
            hit_o <= falling_sel_i ? fall : rise;
      end
   end
endmodule // tof_edge_detect

// file: design/tof_cfg_regs.v
// Chosen here: strobed register access.
`timescale 1ns/100ps
`include "tof_cfg_consts.vh"
module tof_cfg_regs
(
   input wire core_clk_i,
   input wire reset_i,
   input wire [3:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [31:0] rdata_o,
   input wire timeout_evt_i,
   input wire end_hits_evt_i,
   input wire alu_done_evt_i,
   input wire nvm_done_evt_i,
   input wire [31:0] alu_result_i,
   input wire measuring_i,
   input wire stop1_pin_i,
   input wire stop2_pin_i,
   input wire stop_falling_sel_i,
   output wire stop1_hit_o,
   output wire stop2_hit_o,
   output reg [31:0] result_o,
   output wire irq_o,
   output wire [18:0] stop_gate_delay_hit_one_o,
   output wire [18:0] stop_gate_delay_hit_two_o,
   output wire [18:0] stop_gate_delay_hit_three_o,
   output reg [17:0] timeout_cycles_o,
   output reg fire_up_en_o,
   output reg fire_down_en_o,
   output reg fire_down_invert_o,
   output wire start_noise_on_o,
   output wire phase_noise_on_o,
   output wire [2:0] fire_repeat_o,
   output wire [14:0] per_pulse_phase_invert_o,
   output wire analog_power_o,
   output wire stops_analog_o
);
   reg [31:0] word2_q;
   reg [31:0] word3_q;
   reg [31:0] word4_q;
   reg [31:0] word5_q;
   reg [31:0] word6_q;
   reg [3:0] irq_stat_q;
   reg [3:0] irq_mask_q;
   reg [31:0] rdata_d;
   wire [3:0] irq_src;
   wire [3:0] irq_clr;
   wire [2:0] irq_en3;
   wire [1:0] timeout_predivider_sel;
   wire timeout_error_code_on;
   wire [2:0] pulse_output_config;
   wire ch1_edge_select;
   wire ch2_edge_select;
   wire [7:0] user_tag_word2;
   wire [7:0] user_tag_word3;
   wire [7:0] user_tag_word4;
   wire [7:0] user_tag_word5;
   wire wr_w2;
   wire wr_w3;
   wire wr_w4;
   wire wr_w5;
   wire wr_w6;
   wire wr_mask;
   wire wr_stat;

   function wr_hit;
      input [3:0] a;
      input [3:0] idx;
      input w;
      begin
         wr_hit = w & (a == idx);
      end
   endfunction

   // delay fields are 14 integer + 5 fraction bits, reference periods
   function [18:0] delay_field;
      input [31:0] w;
      begin
         delay_field = w[`F_DELAY_HI:`F_DELAY_LO];
      end
   endfunction

   // unmapped indices decode to nothing, so their writes fall away
   assign wr_w2 = wr_hit(addr_i, `CFG_IDX_W2, wr_i);
   assign wr_w3 = wr_hit(addr_i, `CFG_IDX_W3, wr_i);
   assign wr_w4 = wr_hit(addr_i, `CFG_IDX_W4, wr_i);
   assign wr_w5 = wr_hit(addr_i, `CFG_IDX_W5, wr_i);
   assign wr_w6 = wr_hit(addr_i, `CFG_IDX_W6, wr_i);
   assign wr_mask = wr_hit(addr_i, `CFG_IDX_IRQ_MASK, wr_i);
   assign wr_stat = wr_hit(addr_i, `CFG_IDX_IRQ_STAT, wr_i);

   always @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         word2_q <= `CFG_RST_W2;
         word3_q <= `CFG_RST_W3;
         word4_q <= `CFG_RST_W4;
         word5_q <= `CFG_RST_W5;
         word6_q <= `CFG_RST_W6;
         irq_mask_q <= 4'h0;
      end
      else
      begin
         if (wr_w2)
         begin
            word2_q <= wdata_i;
         end
         if (wr_w3)
         begin
            word3_q <= wdata_i;
         end
         if (wr_w4)
         begin
            word4_q <= wdata_i;
         end
         if (wr_w5)
         begin
            word5_q <= wdata_i;
         end
         if (wr_w6)
         begin
            word6_q <= wdata_i;
         end
         if (wr_mask)
         begin
            irq_mask_q <= wdata_i[3:0];
         end
      end
   end

   // config words are write-only on the real part; readback aids software
   always @*
   begin
      rdata_d = 32'h00000000;
      case (addr_i)
         `CFG_IDX_W2: rdata_d = word2_q;
         `CFG_IDX_W3: rdata_d = word3_q;
         `CFG_IDX_W4: rdata_d = word4_q;
         `CFG_IDX_W5: rdata_d = word5_q;
         `CFG_IDX_W6: rdata_d = word6_q;
         `CFG_IDX_IRQ_STAT: rdata_d = {28'h0000000, irq_stat_q};
         `CFG_IDX_IRQ_MASK: rdata_d = {28'h0000000, irq_mask_q};
         default: rdata_d = 32'h00000000;
      endcase
   end

   always @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         rdata_o <= 32'h00000000;
      end
      else if (rd_i)
      begin
         rdata_o <= rdata_d;
      end
      else
      begin
         rdata_o <= 32'h00000000;
      end
   end

   assign irq_en3 = word2_q[`F_IRQ_EN_HI:`F_IRQ_EN_LO];
   // only enabled sources are captured
   assign irq_src = {nvm_done_evt_i & word6_q[`F_W6_NVM_EN],
                     timeout_evt_i & irq_en3[2],
                     end_hits_evt_i & irq_en3[1],
                     alu_done_evt_i & irq_en3[0]};
   assign irq_clr = wr_stat ? wdata_i[3:0] : 4'h0;

   // set wins over a simultaneous write-one-to-clear
   always @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         irq_stat_q <= 4'h0;
      end
      else
      begin
         irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_src;
      end
   end

   assign irq_o = |(irq_stat_q & irq_mask_q);

   assign ch2_edge_select = word2_q[`F_EDGE2];
   assign ch1_edge_select = word2_q[`F_EDGE1];

   tof_edge_detect u_edge1
   (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .stop_pin_i(stop1_pin_i),
      .both_edges_i(ch1_edge_select),
      .falling_sel_i(stop_falling_sel_i),
      .hit_o(stop1_hit_o)
   );

   tof_edge_detect u_edge2
   (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .stop_pin_i(stop2_pin_i),
      .both_edges_i(ch2_edge_select),
      .falling_sel_i(stop_falling_sel_i),
      .hit_o(stop2_hit_o)
   );

   assign stop_gate_delay_hit_one_o = delay_field(word2_q);
   assign stop_gate_delay_hit_two_o = delay_field(word3_q);
   assign stop_gate_delay_hit_three_o = delay_field(word4_q);

   assign timeout_error_code_on = word3_q[`F_ERRVAL];
   assign timeout_predivider_sel = word3_q[`F_TIMO_HI:`F_TIMO_LO];

   // error code only substitutes when a timeout is the cause
   always @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         result_o <= 32'h00000000;
      end
      else if (timeout_evt_i & timeout_error_code_on)
      begin
         result_o <= `TIMEOUT_ERR_CODE;
      end
      else if (alu_done_evt_i)
      begin
         result_o <= alu_result_i;
      end
   end

   // timeout expressed in high speed clock cycles
   always @(posedge core_clk_i)
   begin
      if (reset_i)
         timeout_cycles_o <= 18'h00000;
      else
      begin
         case (timeout_predivider_sel)
            2'h0:
            begin
               timeout_cycles_o <= `TIMO_CYC_0;
            end
            2'h1:
            begin
               timeout_cycles_o <= `TIMO_CYC_1;
            end
            2'h2:
            begin
               timeout_cycles_o <= `TIMO_CYC_2;
            end
            default:
            begin
               timeout_cycles_o <= `TIMO_CYC_3;
            end
         endcase
      end
   end

   assign pulse_output_config = word5_q[`F_CONF_HI:`F_CONF_LO];

   // both-mode overrides individual enables
   always @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         fire_up_en_o <= 1'b0;
         fire_down_en_o <= 1'b0;
         fire_down_invert_o <= 1'b0;
      end
      else
      begin
         case (pulse_output_config)
            3'h0:
            begin
               fire_up_en_o <= 1'b0;
               fire_down_en_o <= 1'b0;
               fire_down_invert_o <= 1'b0;
            end
            3'h1:
            begin
               fire_up_en_o <= 1'b0;
               fire_down_en_o <= 1'b1;
               fire_down_invert_o <= 1'b0;
            end
            3'h2:
            begin
               fire_up_en_o <= 1'b1;
               fire_down_en_o <= 1'b0;
               fire_down_invert_o <= 1'b0;
            end
            // forbidden code: host never writes it, both enables kept
            3'h3:
            begin
               fire_up_en_o <= 1'b1;
               fire_down_en_o <= 1'b1;
               fire_down_invert_o <= 1'b0;
            end
            3'h4:
            begin
               fire_up_en_o <= 1'b1;
               fire_down_en_o <= 1'b1;
               fire_down_invert_o <= 1'b1;
            end
            3'h5:
            begin
               fire_up_en_o <= 1'b1;
               fire_down_en_o <= 1'b1;
               fire_down_invert_o <= 1'b1;
            end
            3'h6:
            begin
               fire_up_en_o <= 1'b1;
               fire_down_en_o <= 1'b1;
               fire_down_invert_o <= 1'b1;
            end
            3'h7:
            begin
               fire_up_en_o <= 1'b1;
               fire_down_en_o <= 1'b1;
               fire_down_invert_o <= 1'b1;
            end
            default:
            begin
               fire_up_en_o <= 1'b0;
               fire_down_en_o <= 1'b0;
               fire_down_invert_o <= 1'b0;
            end
         endcase
      end
   end

   assign start_noise_on_o = word5_q[`F_SNOISE];
   assign phase_noise_on_o = ~word5_q[`F_PNOISE_OFF];
   assign fire_repeat_o = word5_q[`F_REP_HI:`F_REP_LO];
   // bit 23 must be zero, so only 15 pulse bits leave; 1 inverts a pulse
   assign per_pulse_phase_invert_o = word5_q[`F_PH_HI-1:`F_PH_LO];

   assign stops_analog_o = word6_q[`F_W6_ANALOG];
   assign analog_power_o = word6_q[`F_W6_ANALOG] & measuring_i;

   // tags are stored only and steer nothing
   assign user_tag_word2 = word2_q[`F_TAG_HI:0];
   assign user_tag_word3 = word3_q[`F_TAG_HI:0];
   assign user_tag_word4 = word4_q[`F_TAG_HI:0];
   assign user_tag_word5 = word5_q[`F_TAG_HI:0];
endmodule // tof_cfg_regs

// file: verif/tof_cfg_regs_monitor.sv
`timescale 1ns/100ps
module tof_cfg_regs_monitor
(
   input wire core_clk_i,
   input wire reset_i,
   input wire [3:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire measuring_i,
   input wire [18:0] stop_gate_delay_hit_one_o,
   input wire fire_up_en_o,
   input wire fire_down_en_o,
   input wire fire_down_invert_o,
   input wire start_noise_on_o,
   input wire phase_noise_on_o,
   input wire [2:0] fire_repeat_o,
   input wire [14:0] per_pulse_phase_invert_o,
   input wire analog_power_o,
   input wire stops_analog_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   sequence w2;
      wr_i && addr_i == 4'h2;
   endsequence
   sequence w5;
      wr_i && addr_i == 4'h5;
   endsequence
   a_delay_one: assert property (w2 |=> stop_gate_delay_hit_one_o == $past(wdata_i[26:8]))
      else $error("delay one wrong");
   a_fire_up: assert property (w5 ##0 !wdata_i[31] |=> ##1 fire_up_en_o == $past(wdata_i[30], 2))
      else $error("fire up enable wrong");
   a_fire_down: assert property (w5 ##0 !wdata_i[31] |=> ##1 fire_down_en_o == $past(wdata_i[29], 2))
      else $error("fire down enable wrong");
   a_fire_invert: assert property (w5 |=> ##1 fire_down_invert_o == $past(wdata_i[31], 2))
      else $error("fire invert wrong");
   a_start_noise: assert property (w5 |=> start_noise_on_o == $past(wdata_i[28]))
      else $error("start noise wrong");
   a_phase_noise: assert property (w5 |=> phase_noise_on_o != $past(wdata_i[27]))
      else $error("phase noise wrong");
   a_repeat_count: assert property (w5 |=> fire_repeat_o == $past(wdata_i[26:24]))
      else $error("repeat count wrong");
   a_phase_bits: assert property (w5 |=> per_pulse_phase_invert_o == $past(wdata_i[22:8]))
      else $error("phase bits wrong");
   a_analog_power: assert property (analog_power_o == (stops_analog_o && measuring_i))
      else $error("analog power wrong");
   cover property (w2);
   cover property (w5 ##2 fire_down_invert_o);
   cover property (analog_power_o);
endmodule // tof_cfg_regs_monitor

bind tof_cfg_regs tof_cfg_regs_monitor mon (.core_clk_i(core_clk_i), .reset_i(reset_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .measuring_i(measuring_i),
   .stop_gate_delay_hit_one_o(stop_gate_delay_hit_one_o), .fire_up_en_o(fire_up_en_o),
   .fire_down_en_o(fire_down_en_o),
   .fire_down_invert_o(fire_down_invert_o), .start_noise_on_o(start_noise_on_o),
   .phase_noise_on_o(phase_noise_on_o), .fire_repeat_o(fire_repeat_o),
   .per_pulse_phase_invert_o(per_pulse_phase_invert_o), .analog_power_o(analog_power_o),
   .stops_analog_o(stops_analog_o));

// file: verif/tof_host_model.sv
`timescale 1ns/100ps
module tof_host_model
(
   input wire core_clk_i,
   input wire [31:0] rdata_i,
   output reg [3:0] addr_o,
   output reg [31:0] wdata_o,
   output reg wr_o,
   output reg rd_o
);
   reg analog_q = 1'b0;
   initial {addr_o, wdata_o, wr_o, rd_o} = 38'h0;
   task wr(input [3:0] a, input [31:0] d);
      reg [31:0] v;
      v = d;
      if (a == 4'h6)
         analog_q = d[11];
      if (a == 4'h5)
         v[23] = 1'b0;
      if (a == 4'h5 && v[31:29] == 3'b011)
         v[31] = 1'b1;
      if (!analog_q && a >= 4'h2 && a <= 4'h4)
         v[26:8] = 19'h0;
      @(posedge core_clk_i);
      {wr_o, addr_o, wdata_o} <= {1'b1, a, v};
      @(posedge core_clk_i);
      {wr_o, wdata_o} <= {1'b0, ~v};
   endtask
   task rd(input [3:0] a, output [31:0] d);
      @(posedge core_clk_i);
      {rd_o, addr_o} <= {1'b1, a};
      @(posedge core_clk_i);
      rd_o <= 1'b0;
      @(posedge core_clk_i);
      d = rdata_i;
   endtask
endmodule // tof_host_model

// file: verif/tof_cfg_regs_bench.sv
`timescale 1ns/100ps
`include "tof_cfg_consts.vh"
module tof_cfg_regs_bench;
   logic core_clk_i = 0, reset_i = 1, measuring = 0, fsel = 0;
   logic [1:0] stops = 0;
   logic [3:0] ev = 0, addr;
   logic [31:0] alu_res = 0, x = 32'h1, d, m [0:15];
   wire [31:0] wdata, rdata, result;
   wire [17:0] tcyc;
   wire wr, rd, hit1, hit2, irq;
   integer n_fail = 0, num_checks = 0, cyc = 0, h1 = 0, h2 = 0, i;
   always #2.5 core_clk_i = ~core_clk_i;
   tof_host_model host (.core_clk_i(core_clk_i), .rdata_i(rdata), .addr_o(addr),
      .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
   tof_cfg_regs dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .timeout_evt_i(ev[2]),
      .end_hits_evt_i(ev[1]), .alu_done_evt_i(ev[0]), .nvm_done_evt_i(ev[3]),
      .alu_result_i(alu_res), .measuring_i(measuring), .stop1_pin_i(stops[1]),
      .stop2_pin_i(stops[0]), .stop_falling_sel_i(fsel), .stop1_hit_o(hit1),
      .stop2_hit_o(hit2), .result_o(result), .irq_o(irq), .stop_gate_delay_hit_one_o(),
      .stop_gate_delay_hit_two_o(), .stop_gate_delay_hit_three_o(),
      .timeout_cycles_o(tcyc), .fire_up_en_o(), .fire_down_en_o(), .fire_down_invert_o(),
      .start_noise_on_o(), .phase_noise_on_o(), .fire_repeat_o(),
      .per_pulse_phase_invert_o(), .analog_power_o(), .stops_analog_o());
   function logic [31:0] rnd();
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction
   task finish_test;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         $display("BAD %0t got %h want %h", $time, got, exp);
         n_fail++;
      end
   endtask
   task pulse(input [3:0] p);
      @(posedge core_clk_i) ev <= p;
      @(posedge core_clk_i) ev <= 4'h0;
      @(negedge core_clk_i);
   endtask
   task readall;
      for (int j = 0; j < 16; j++)
      begin
         host.rd(j[3:0], d);
         chk(d, m[j]);
      end
   endtask
   always @(posedge core_clk_i)
   begin
      measuring <= x[7];
      h1 += hit1;
      h2 += hit2;
      if (++cyc == 20000)
      begin
         n_fail++;
         finish_test();
      end
   end
   initial
   begin
      m = '{default: 32'h0};
      m[2] = `CFG_RST_W2;
      m[3] = `CFG_RST_W3;
      m[4] = `CFG_RST_W4;
      repeat (2) @(posedge core_clk_i);
      reset_i <= 1'b0;
      readall();
      host.wr(4'h6, 32'h00200800);
      m[6] = 32'h00200800;
      for (i = 2; i < 6; i++)
      begin
         d = rnd();
         if (i == 5)
            d = {d[31] | (d[31:29] == 3'b011), d[30:24], 1'b0, d[22:0]};
         host.wr(i[3:0], d);
         m[i] = d;
      end
      host.wr(4'hf, rnd());
      readall();
      $display("config readback done");
      for (i = 0; i < 4; i++)
      begin
         host.wr(4'h3, i << 27);
         repeat (2) @(negedge core_clk_i);
         chk(tcyc, 32'd256 << (2 * i));
      end
      host.wr(4'h2, 32'he0000000);
      host.wr(4'h9, 32'hf);
      for (i = 0; i < 4; i++)
      begin
         pulse(1 << i);
         chk(irq, 1);
         host.rd(4'h8, d);
         chk(d, 1 << i);
         host.wr(4'h8, 1 << i);
         @(negedge core_clk_i);
         chk(irq, 0);
      end
      host.wr(4'h9, 32'h0);
      pulse(4'h4);
      chk(irq, 0);
      host.wr(4'h8, 32'h4);
      host.wr(4'h2, 32'h0);
      pulse(4'h1);
      host.rd(4'h8, d);
      chk(d, 0);
      $display("interrupt done");
      host.wr(4'h3, 32'h20000000);
      pulse(4'h4);
      chk(result, `TIMEOUT_ERR_CODE);
      @(posedge core_clk_i) alu_res <= rnd();
      pulse(4'h1);
      chk(result, alu_res);
      host.wr(4'h3, 32'h0);
      pulse(4'h4);
      chk(result, alu_res);
      $display("error code done");
      host.wr(4'h2, 32'h08000000);
      @(negedge core_clk_i);
      h1 = 0;
      h2 = 0;
      @(posedge core_clk_i) stops <= 2'b11;
      repeat (8) @(posedge core_clk_i);
      stops <= 2'b00;
      repeat (8) @(negedge core_clk_i);
      chk(h1, 2);
      chk(h2, 1);
      h1 = 0;
      h2 = 0;
      @(posedge core_clk_i) {fsel, stops} <= 3'b111;
      repeat (8) @(negedge core_clk_i);
      chk(h1, 1);
      chk(h2, 0);
      @(posedge core_clk_i) stops <= 2'b00;
      repeat (8) @(negedge core_clk_i);
      chk(h1, 2);
      chk(h2, 1);
      $display("edge select done");
      finish_test();
   end
endmodule // tof_cfg_regs_bench
